// ---- parallel_port_mode_signaling_test.sv ----
// self-checking bench for the parallel port pin engine
`timescale 1ns/100ps
module parallel_port_mode_signaling_test;
  import pp_pkg::*;
  localparam int TMO = 50;
  typedef struct packed {
    pp_mode_e m;
    logic [2:0] ctl;
    logic [2:0] st;
    logic [7:0] d;
    logic c;
  } pp_row_s;
  pp_row_s rows [0:7] = '{
    '{PP_COMPAT, 3'h0, 3'h3, 8'h00, 1'b0}, '{PP_COMPAT, 3'h7, 3'h4, 8'hFF, 1'b0},
    '{PP_COMPAT, 3'h2, 3'h2, 8'h5A, 1'b0}, '{PP_ECP, 3'h0, 3'h7, 8'hA5, 1'b0},
    '{PP_ECP, 3'h0, 3'h7, 8'h3C, 1'b1}, '{PP_EPP, 3'h4, 3'h3, 8'h81, 1'b0},
    '{PP_EPP, 3'h0, 3'h3, 8'h7E, 1'b1}, '{PP_COMPAT, 3'h1, 3'h3, 8'hC3, 1'b0}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pp_mode_e mode = PP_COMPAT;
  logic prn_init = 1'b0, prn_autolf = 1'b0, prn_select = 1'b0;
  logic tx_valid = 1'b0, tx_cmd = 1'b0, rd_req = 1'b0, rd_addr = 1'b0;
  logic rev_en = 1'b0, rx_ready = 1'b0, mute = 1'b0, intr = 1'b0;
  logic [7:0] tx_data = 8'h00, src = 8'h00;
  logic [3:0] lag = 4'h0;
  logic [2:0] st = 3'h3;
  logic tx_ready, rx_valid, rx_cmd, epp_timeout, periph_intr, periph_req;
  logic paper_out, online, fault, link_idle, strobe_n, autofd_n, slctin_n, init_n;
  logic ack_n, busy, pe, slct, error_n, pd_oe, got_cmd;
  logic [7:0] rx_data, pd_o, pd_drv, pd_w, got;
  int n_got, n_rev, n0, k;
  int n_tests = 0;
  int n_mismatch = 0;

  assign pd_w = pd_oe ? pd_o : pd_drv;
  always #50 clk = ~clk;

  pp_port #(.EPP_TMO_CYC(TMO)) i_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .mode(mode),
    .prn_init(prn_init), .prn_autolf(prn_autolf), .prn_select(prn_select),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_cmd(tx_cmd),
    .rd_req(rd_req), .rd_addr(rd_addr), .rev_en(rev_en), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_cmd(rx_cmd), .epp_timeout(epp_timeout),
    .periph_intr(periph_intr), .periph_req(periph_req), .paper_out(paper_out),
    .online(online), .fault(fault), .link_idle(link_idle), .strobe_n(strobe_n),
    .autofd_n(autofd_n), .slctin_n(slctin_n), .init_n(init_n), .ack_n(ack_n),
    .busy(busy), .pe(pe), .slct(slct), .error_n(error_n), .pd_i(pd_w), .pd_o(pd_o),
    .pd_oe(pd_oe));

  pp_periph i_per (.clk(clk), .mode(mode), .lag(lag), .mute(mute), .intr(intr), .st(st),
    .src(src), .strobe_n(strobe_n), .autofd_n(autofd_n), .slctin_n(slctin_n),
    .init_n(init_n), .pd(pd_w), .ack_n(ack_n), .busy(busy), .pe(pe), .slct(slct),
    .error_n(error_n), .pd_drv(pd_drv), .got(got), .got_cmd(got_cmd), .n_got(n_got),
    .n_rev(n_rev));

  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic send(input logic [7:0] d, input logic c);
    int j;
    j = 0;
    tx_valid <= 1'b1;
    tx_data <= d;
    tx_cmd <= c;
    do
    begin
      @(negedge clk);
      j++;
    end
    while (tx_ready !== 1'b1 && j < 300);
    @(posedge clk);
    tx_valid <= 1'b0;
    chk(j < 300, "byte refused");
  endtask

  task automatic idle();
    int j;
    j = 0;
    do
    begin
      @(negedge clk);
      j++;
    end
    while (link_idle !== 1'b1 && j < 600);
    @(posedge clk);
    chk(j < 600, "no return to idle");
  endtask

  // leaves rx_ready high so drains run back to back
  task automatic recv(input logic [7:0] d, input logic c);
    int j;
    j = 0;
    rx_ready <= 1'b1;
    do
    begin
      @(negedge clk);
      j++;
    end
    while (rx_valid !== 1'b1 && j < 600);
    chk(j < 600, "no received word");
    chk(rx_data === d && rx_cmd === c, "received word");
    @(posedge clk);
  endtask

  initial
  begin
    cyc(40000);
    n_mismatch++;
    $display("unexpected at %0t: run hung", $time);
    test_done();
  end

  initial
  begin
    repeat (3) @(negedge clk) chk({strobe_n, autofd_n, slctin_n, init_n, pd_oe} === 5'h1E, "reset");
    @(posedge clk) rst_n <= 1'b1;
    cyc(3);
    foreach (rows[i])
    begin
      mode <= rows[i].m;
      {prn_init, prn_autolf, prn_select} <= rows[i].ctl;
      st <= rows[i].st;
      lag <= 4'(i);
      cyc(4);
      n0 = n_got;
      send(rows[i].d, rows[i].c);
      idle();
      chk(n_got == n0 + 1 && got === rows[i].d, "byte at far side");
      chk(got_cmd === (rows[i].m != PP_COMPAT && rows[i].c), "command mark");
      chk(paper_out === rows[i].st[2] && online === rows[i].st[1], "status");
      chk(fault === (rows[i].m == PP_COMPAT && !rows[i].st[0]), "fault");
      chk(init_n === (rows[i].m == PP_ECP || !rows[i].ctl[2]), "init level");
      if (rows[i].m == PP_COMPAT)
        chk({autofd_n, slctin_n} === ~rows[i].ctl[1:0], "controls");
      else
        chk(slctin_n === 1'b1, "select line");
    end
    mode <= PP_NIBBLE;
    src <= 8'h96;
    lag <= 4'h6;
    cyc(4);
    rd_req <= 1'b1;
    cyc(1);
    rd_req <= 1'b0;
    cyc(3);
    @(negedge clk);
    chk(autofd_n === 1'b0 && slctin_n === 1'b1, "nibble ready");
    recv(8'h96, 1'b0);
    rx_ready <= 1'b0;
    idle();
    mode <= PP_EPP;
    cyc(2);
    for (int a = 0; a < 2; a++)
    begin
      rd_addr <= a[0];
      rd_req <= 1'b1;
      cyc(1);
      rd_req <= 1'b0;
      recv(a[0] ? 8'h69 : 8'h96, a[0]);
      rx_ready <= 1'b0;
      idle();
    end
    mute <= 1'b1;
    send(8'h3C, 1'b0);
    k = 0;
    while (epp_timeout !== 1'b1 && k < 4 * TMO)
    begin
      @(negedge clk);
      k++;
    end
    chk(k < 4 * TMO, "abort pulse");
    mute <= 1'b0;
    idle();
    intr <= 1'b1;
    cyc(4);
    chk(periph_intr === 1'b1, "interrupt seen");
    intr <= 1'b0;
    cyc(4);
    chk(periph_intr === 1'b0, "interrupt gone");
    mode <= PP_ECP;
    st <= 3'h6;
    src <= 8'h40;
    lag <= 4'h1;
    cyc(4);
    chk(periph_req === 1'b1, "reverse waiting");
    rev_en <= 1'b1;
    cyc(200);
    chk(init_n === 1'b0 && rx_valid === 1'b1 && n_rev < 4, "stalled reverse");
    for (int b = 0; b < 4; b++)
      recv(8'h40 + 8'(b), b[0]);
    rx_ready <= 1'b0;
    rev_en <= 1'b0;
    st <= 3'h7;
    idle();
    chk(n_rev == 4 && init_n === 1'b1, "reverse closed");
    test_done();
  end
endmodule

// ---- pp_buf2.sv ----
// two-entry buffer between the pin engine and the receive stream
`timescale 1ns/100ps
module pp_buf2 #(
  parameter int W = 9,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;

  assign in_ready = (cnt != (AW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp];
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end
    else
    begin
      if (push)
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      if (pop)
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      if (push && !pop)
        cnt <= cnt + 1'b1;
      else if (pop && !push)
        cnt <= cnt - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp] <= in_data;
  end
endmodule

// ---- pp_periph.sv ----
// behavioural peripheral on the far side of the parallel port pins
`timescale 1ns/100ps
module pp_periph (
  input wire logic clk,
  input wire pp_pkg::pp_mode_e mode,
  input wire logic [3:0] lag,
  input wire logic mute,
  input wire logic intr,
  input wire logic [2:0] st,
  input wire logic [7:0] src,
  input wire logic strobe_n,
  input wire logic autofd_n,
  input wire logic slctin_n,
  input wire logic init_n,
  input wire logic [7:0] pd,
  output logic ack_n,
  output logic busy,
  output logic pe,
  output logic slct,
  output logic error_n,
  output logic [7:0] pd_drv,
  output logic [7:0] got,
  output logic got_cmd,
  output int n_got,
  output int n_rev
);
  import pp_pkg::*;

  // all pin changes land just after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic compat_byte();
    got = pd;
    got_cmd = 1'b0;
    busy = 1'b1;
    while (!strobe_n) step(1);
    step(lag);
    ack_n = 1'b0;
    step(3);
    ack_n = 1'b1;
    busy = 1'b0;
    n_got++;
  endtask

  task automatic nib(input logic [3:0] v);
    {busy, pe, slct, error_n} = v;
    step(lag);
    ack_n = 1'b0;
    while (!autofd_n) step(1);
    step(1);
    ack_n = 1'b1;
  endtask

  task automatic nib_byte();
    nib(src[3:0]);
    while (autofd_n) step(1);
    nib(src[7:4]);
  endtask

  task automatic epp_cycle();
    if (!strobe_n)
    begin
      got = pd;
      got_cmd = !slctin_n;
      n_got++;
    end
    else
      pd_drv = slctin_n ? src : ~src;
    step(lag);
    busy = !mute;
    while (!autofd_n || !slctin_n) step(1);
    step(1);
    busy = 1'b0;
    // released lines must not keep the old value
    pd_drv = ~pd_drv;
  endtask

  task automatic ecp_fwd();
    got = pd;
    got_cmd = !autofd_n;
    step(lag);
    busy = 1'b1;
    while (!strobe_n) step(1);
    step(1);
    busy = 1'b0;
    n_got++;
  endtask

  task automatic ecp_rev();
    step(lag);
    pe = 1'b0;
    repeat (4)
    begin
      while (autofd_n) step(1);
      pd_drv = src + 8'(n_rev);
      busy = !n_rev[0];
      step(1);
      ack_n = 1'b0;
      while (!autofd_n) step(1);
      step(1);
      ack_n = 1'b1;
      n_rev++;
    end
    pd_drv = ~pd_drv;
    while (!init_n) step(1);
  endtask

  initial
  begin
    pd_drv = 8'h00;
    got = 8'h00;
    got_cmd = 1'b0;
    n_got = 0;
    n_rev = 0;
    forever
    begin
      {pe, slct, error_n} = st;
      busy = 1'b0;
      ack_n = !(mode == PP_EPP && intr);
      step(1);
      if (mode == PP_COMPAT && !strobe_n)
        compat_byte();
      else if (mode == PP_NIBBLE && !autofd_n)
        nib_byte();
      else if (mode == PP_EPP && !(autofd_n && slctin_n))
        epp_cycle();
      else if (mode == PP_ECP && !strobe_n)
        ecp_fwd();
      else if (mode == PP_ECP && !init_n)
        ecp_rev();
    end
  end
endmodule

// ---- pp_pkg.sv ----
// shared constants and types for the parallel port pin engine
package pp_pkg;
  localparam int PP_DW = 8;
  localparam int PP_NIB = 4;
  localparam int PP_SYNC_W = 13;
  localparam int PP_CLK_NS = 100;
  localparam int PP_SETUP_NS = 600;
  localparam int PP_STROBE_NS = 600;
  localparam int PP_EPP_TMO_US = 10000;
  localparam int PP_SETUP_CYC = (PP_SETUP_NS + PP_CLK_NS - 1) / PP_CLK_NS;
  localparam int PP_STROBE_CYC = (PP_STROBE_NS + PP_CLK_NS - 1) / PP_CLK_NS;
  localparam int PP_EPP_TMO_CYC = (PP_EPP_TMO_US * 1000) / PP_CLK_NS;
  localparam int PP_CNT_W = 17;
  localparam int PP_BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    PP_COMPAT = 2'b00,
    PP_NIBBLE = 2'b01,
    PP_EPP = 2'b10,
    PP_ECP = 2'b11
  } pp_mode_e;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_CSET = 4'b0001,
    S_CSTB = 4'b0010,
    S_CWAIT = 4'b0011,
    S_NWAIT = 4'b0100,
    S_NTAKE = 4'b0101,
    S_ESET = 4'b0110,
    S_ESTB = 4'b0111,
    S_FSET = 4'b1000,
    S_FCLK = 4'b1001,
    S_FREL = 4'b1010,
    S_RREQ = 4'b1011,
    S_RWAIT = 4'b1100,
    S_RACK = 4'b1101
  } pp_state_e;
endpackage

// ---- pp_port.sv ----
// parallel port pin engine: compatibility, nibble, EPP and ECP handshakes
`timescale 1ns/100ps
module pp_port
  import pp_pkg::*;
#(
  parameter int EPP_TMO_CYC = pp_pkg::PP_EPP_TMO_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire pp_pkg::pp_mode_e mode,
  input wire logic prn_init,
  input wire logic prn_autolf,
  input wire logic prn_select,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [pp_pkg::PP_DW-1:0] tx_data,
  input wire logic tx_cmd,
  input wire logic rd_req,
  input wire logic rd_addr,
  input wire logic rev_en,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [pp_pkg::PP_DW-1:0] rx_data,
  output logic rx_cmd,
  output logic epp_timeout,
  output logic periph_intr,
  output logic periph_req,
  output logic paper_out,
  output logic online,
  output logic fault,
  output logic link_idle,
  output logic strobe_n,
  output logic autofd_n,
  output logic slctin_n,
  output logic init_n,
  input wire logic ack_n,
  input wire logic busy,
  input wire logic pe,
  input wire logic slct,
  input wire logic error_n,
  input wire logic [pp_pkg::PP_DW-1:0] pd_i,
  output logic [pp_pkg::PP_DW-1:0] pd_o,
  output logic pd_oe
);
  import pp_pkg::*;

  function automatic logic is_1284(input pp_mode_e m);
    is_1284 = (m == PP_NIBBLE) || (m == PP_ECP);
  endfunction

  logic rst_q;
  logic rst_s_n;
  logic [PP_SYNC_W-1:0] sync_in;
  logic [PP_SYNC_W-1:0] sync_out;
  logic ack_s;
  logic busy_s;
  logic pe_s;
  logic slct_s;
  logic err_s;
  logic [PP_DW-1:0] pd_s;
  pp_state_e state;
  pp_state_e next_state;
  pp_mode_e cur_mode;
  pp_mode_e next_mode;
  logic [PP_CNT_W-1:0] tcnt;
  logic [PP_DW-1:0] out_byte;
  logic out_cmd;
  logic e_wr;
  logic e_addr;
  logic nib_hi;
  logic [PP_NIB-1:0] nib_lo;
  logic hold_valid;
  logic [PP_DW-1:0] hold_data;
  logic hold_cmd;
  logic hold_ready;
  logic tmo_hit;
  logic next_strobe_n;
  logic next_autofd_n;
  logic next_slctin_n;
  logic next_init_n;
  logic next_pd_oe;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_q <= 1'b0;
      rst_s_n <= 1'b0;
    end
    else
    begin
      rst_q <= 1'b1;
      rst_s_n <= rst_q;
    end
  end

  assign sync_in = {pd_i, ack_n, busy, pe, slct, error_n};

  pp_sync #(
    .W(PP_SYNC_W)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_s_n),
    .ce(ce),
    .din(sync_in),
    .dout(sync_out)
  );

  assign {pd_s, ack_s, busy_s, pe_s, slct_s, err_s} = sync_out;

  // status reinterpreted per mode
  assign paper_out = pe_s;
  assign online = slct_s;
  assign fault = (cur_mode == PP_COMPAT) && !err_s;
  assign periph_intr = (cur_mode == PP_EPP) && !ack_s;
  assign periph_req = (cur_mode == PP_ECP) && !err_s;
  assign link_idle = (state == S_IDLE);
  assign tmo_hit = (tcnt == PP_CNT_W'(EPP_TMO_CYC - 1));

  // forward bytes are taken only from idle; compat and EPP also wait for busy low, ECP only for rev_en low
  always_comb
  begin
    tx_ready = 1'b0;
    if (ce && state == S_IDLE)
    begin
      case (mode)
        PP_COMPAT: tx_ready = !busy_s;
        PP_EPP: tx_ready = !busy_s && !rd_req;
        PP_ECP: tx_ready = !rev_en;
        default: tx_ready = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE:
      begin
        if (tx_valid && tx_ready)
        begin
          case (mode)
            PP_COMPAT: next_state = S_CSET;
            PP_EPP: next_state = S_ESET;
            default: next_state = S_FSET;
          endcase
        end
        else if (ce && rd_req && !hold_valid && mode == PP_NIBBLE)
          next_state = S_NWAIT;
        else if (ce && rd_req && !hold_valid && mode == PP_EPP && !busy_s)
          next_state = S_ESET;
        else if (ce && rev_en && mode == PP_ECP)
          next_state = S_RREQ;
      end
      S_CSET: if (tcnt == PP_CNT_W'(PP_SETUP_CYC - 1)) next_state = S_CSTB;
      S_CSTB: if (tcnt == PP_CNT_W'(PP_STROBE_CYC - 1)) next_state = S_CWAIT;
      S_CWAIT: if (!busy_s) next_state = S_IDLE;
      S_NWAIT: if (!ack_s && !hold_valid) next_state = S_NTAKE;
      S_NTAKE: if (ack_s) next_state = nib_hi ? S_NWAIT : S_IDLE;
      S_ESET: next_state = S_ESTB;
      S_ESTB: if (busy_s || tmo_hit) next_state = S_IDLE;
      S_FSET: next_state = S_FCLK;
      S_FCLK: if (busy_s) next_state = S_FREL;
      S_FREL: if (!busy_s) next_state = S_IDLE;
      S_RREQ:
      begin
        if (!rev_en)
          next_state = S_IDLE;
        else if (!pe_s)
          next_state = S_RWAIT;
      end
      S_RWAIT:
      begin
        if (!rev_en)
          next_state = S_IDLE;
        else if (!ack_s && !hold_valid)
          next_state = S_RACK;
      end
      S_RACK: if (ack_s) next_state = S_RWAIT;
      default: next_state = S_IDLE;
    endcase
  end

  assign next_mode = (state == S_IDLE) ? mode : cur_mode;

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      state <= S_IDLE;
      cur_mode <= PP_COMPAT;
    end
    else if (ce)
    begin
      state <= next_state;
      cur_mode <= next_mode;
    end
  end

  // one shared timer: setup and strobe width in compat, timeout in EPP
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      tcnt <= '0;
    else if (ce)
    begin
      if (next_state != state)
        tcnt <= '0;
      else
        tcnt <= tcnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      epp_timeout <= 1'b0;
    else if (ce)
      epp_timeout <= (state == S_ESTB) && !busy_s && tmo_hit;
  end

  // forward byte and EPP cycle kind, latched when a cycle starts
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      out_byte <= '0;
      out_cmd <= 1'b0;
      e_wr <= 1'b0;
      e_addr <= 1'b0;
    end
    else if (ce && state == S_IDLE && next_state != S_IDLE)
    begin
      if (tx_valid && tx_ready)
      begin
        out_byte <= tx_data;
        out_cmd <= tx_cmd;
        e_wr <= 1'b1;
        e_addr <= tx_cmd;
      end
      else
      begin
        e_wr <= 1'b0;
        e_addr <= rd_addr;
      end
    end
  end

  // receive capture: nibbles, EPP reads and ECP reverse bytes
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      nib_hi <= 1'b0;
      nib_lo <= '0;
      hold_valid <= 1'b0;
      hold_data <= '0;
      hold_cmd <= 1'b0;
    end
    else if (ce)
    begin
      if (hold_valid && hold_ready)
        hold_valid <= 1'b0;
      if (state == S_NWAIT && next_state == S_NTAKE)
      begin
        if (nib_hi)
        begin
          hold_valid <= 1'b1;
          hold_data <= {busy_s, pe_s, slct_s, err_s, nib_lo};
          hold_cmd <= 1'b0;
        end
        else
          nib_lo <= {busy_s, pe_s, slct_s, err_s};
        nib_hi <= !nib_hi;
      end
      else if (state == S_ESTB && busy_s && !e_wr)
      begin
        hold_valid <= 1'b1;
        hold_data <= pd_s;
        hold_cmd <= e_addr;
      end
      else if (state == S_RWAIT && next_state == S_RACK)
      begin
        hold_valid <= 1'b1;
        hold_data <= pd_s;
        hold_cmd <= !busy_s;
      end
    end
  end

  pp_buf2 #(
    .W(PP_DW + 1),
    .DEPTH(PP_BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst_n(rst_s_n),
    .ce(ce),
    .in_valid(hold_valid),
    .in_ready(hold_ready),
    .in_data({hold_cmd, hold_data}),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data({rx_cmd, rx_data})
  );

  // pin levels follow the state being entered, so pins and state change together
  always_comb
  begin
    next_strobe_n = 1'b1;
    next_autofd_n = 1'b1;
    next_slctin_n = is_1284(next_mode);
    next_init_n = 1'b1;
    next_pd_oe = 1'b0;
    case (next_mode)
      PP_COMPAT:
      begin
        next_strobe_n = (next_state != S_CSTB);
        next_autofd_n = !prn_autolf;
        next_slctin_n = !prn_select;
        next_init_n = !prn_init;
        next_pd_oe = 1'b1;
      end
      PP_NIBBLE:
        next_autofd_n = (next_state != S_NWAIT);
      PP_EPP:
      begin
        if (next_state == S_ESET || next_state == S_ESTB)
        begin
          next_strobe_n = !e_wr_next();
          next_pd_oe = e_wr_next();
        end
        next_autofd_n = !(next_state == S_ESTB && !e_addr_next());
        next_slctin_n = !(next_state == S_ESTB && e_addr_next());
        next_init_n = !prn_init;
      end
      default:
      begin
        if (next_state == S_RREQ || next_state == S_RWAIT || next_state == S_RACK)
        begin
          next_init_n = 1'b0;
          // HostAck low while ready for a byte, high once PeriphClk is seen low
          next_autofd_n = (next_state == S_RACK);
        end
        else
        begin
          next_strobe_n = (next_state != S_FCLK);
          next_autofd_n = !out_cmd_next();
          next_pd_oe = 1'b1;
        end
      end
    endcase
  end

  // cycle attributes as they will stand after this edge
  function automatic logic starting();
    starting = (state == S_IDLE) && (next_state != S_IDLE);
  endfunction

  function automatic logic e_wr_next();
    e_wr_next = starting() ? (tx_valid && tx_ready) : e_wr;
  endfunction

  function automatic logic e_addr_next();
    e_addr_next = starting() ? ((tx_valid && tx_ready) ? tx_cmd : rd_addr) : e_addr;
  endfunction

  function automatic logic out_cmd_next();
    out_cmd_next = (starting() && tx_valid && tx_ready) ? tx_cmd : out_cmd;
  endfunction

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      strobe_n <= 1'b1;
      autofd_n <= 1'b1;
      slctin_n <= 1'b1;
      init_n <= 1'b1;
      pd_oe <= 1'b0;
      pd_o <= '0;
    end
    else if (ce)
    begin
      strobe_n <= next_strobe_n;
      autofd_n <= next_autofd_n;
      slctin_n <= next_slctin_n;
      init_n <= next_init_n;
      pd_oe <= next_pd_oe;
      if (starting() && tx_valid && tx_ready)
        pd_o <= tx_data;
    end
  end

  property p_strobe_width;
    @(posedge clk) disable iff (!rst_s_n)
    ce && $fell(strobe_n) && cur_mode == PP_COMPAT |-> !strobe_n [*6];
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("compat strobe shorter than its width");

  property p_no_send_busy;
    @(posedge clk) disable iff (!rst_s_n)
    ce && state == S_IDLE && busy_s |=> state != S_CSET;
  endproperty
  a_no_send_busy: assert property (p_no_send_busy)
    else $error("compat byte taken while printer busy");

  property p_compat_ctl;
    @(posedge clk) disable iff (!rst_s_n)
    ce && $past(ce) && cur_mode == PP_COMPAT && $past(state) == S_IDLE && state != S_IDLE
      |-> autofd_n == !$past(prn_autolf) && slctin_n == !$past(prn_select)
        && init_n == !$past(prn_init);
  endproperty
  a_compat_ctl: assert property (p_compat_ctl)
    else $error("compat control pins do not follow their inputs");

  property p_hostbusy;
    @(posedge clk) disable iff (!rst_s_n)
    ce && state == S_NWAIT && !ack_s && !hold_valid |=> state == S_NTAKE && autofd_n;
  endproperty
  a_hostbusy: assert property (p_hostbusy)
    else $error("HostBusy not raised after nibble capture");

  property p_active_1284;
    @(posedge clk) disable iff (!rst_s_n)
    is_1284(cur_mode) && $past(is_1284(cur_mode)) |-> slctin_n;
  endproperty
  a_active_1284: assert property (p_active_1284)
    else $error("1284Active low in a 1284 mode");

  property p_epp_strobes;
    @(posedge clk) disable iff (!rst_s_n)
    state == S_ESTB |-> strobe_n == !e_wr && autofd_n == e_addr && slctin_n == !e_addr;
  endproperty
  a_epp_strobes: assert property (p_epp_strobes)
    else $error("EPP strobes wrong for cycle kind");

  property p_epp_end;
    @(posedge clk) disable iff (!rst_s_n)
    ce && state == S_ESTB && busy_s |=> state == S_IDLE && autofd_n && slctin_n && strobe_n;
  endproperty
  a_epp_end: assert property (p_epp_end)
    else $error("EPP cycle not ended when wait went high");

  property p_epp_tmo;
    @(posedge clk) disable iff (!rst_s_n)
    ce && state == S_ESTB && !busy_s && tmo_hit |=> epp_timeout && state == S_IDLE;
  endproperty
  a_epp_tmo: assert property (p_epp_tmo)
    else $error("EPP timeout did not abort the cycle");

  property p_ecp_fwd;
    @(posedge clk) disable iff (!rst_s_n)
    ce && state == S_FCLK && busy_s |=> strobe_n && state == S_FREL;
  endproperty
  a_ecp_fwd: assert property (p_ecp_fwd)
    else $error("HostClk not released after PeriphAck");

  property p_ecp_rev;
    @(posedge clk) disable iff (!rst_s_n)
    state == S_RREQ || state == S_RWAIT || state == S_RACK |-> !init_n;
  endproperty
  a_ecp_rev: assert property (p_ecp_rev)
    else $error("reverse request not held low");
endmodule

// ---- pp_sync.sv ----
// two-flop synchroniser for the peripheral status and data pins
`timescale 1ns/100ps
module pp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      dout <= '0;
    end
    else if (ce)
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
